// File: rtl/wesa_pkg.sv
// constants, field positions and types of the wake and management event block
package wesa_pkg;

    // ************************************************
    // register map
    // ************************************************
    localparam logic [7:0] ADDR_WAKE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_WAKE_ST1 = 8'h02;
    localparam logic [7:0] ADDR_WAKE_EN1 = 8'h03;
    localparam logic [7:0] ADDR_WAKE_ST3 = 8'h04;
    localparam logic [7:0] ADDR_WAKE_EN3 = 8'h05;
    localparam logic [7:0] ADDR_WAKE_ST2 = 8'h06;
    localparam logic [7:0] ADDR_WAKE_EN2 = 8'h07;
    localparam logic [7:0] ADDR_MGMT_ST1 = 8'h10;
    localparam logic [7:0] ADDR_MGMT_EN1 = 8'h11;
    localparam logic [7:0] ADDR_MGMT_ST2 = 8'h12;
    localparam logic [7:0] ADDR_MGMT_EN2 = 8'h13;
    localparam logic [7:0] ADDR_MGMT_ST3 = 8'h14;
    localparam logic [7:0] ADDR_MGMT_EN3 = 8'h15;
    localparam logic [7:0] ADDR_GPIO_POL = 8'h20;
    localparam logic [7:0] ADDR_GPIO_DUAL = 8'h21;
    localparam logic [7:0] ADDR_WAKE_PIN = 8'h22;
    localparam logic [7:0] ADDR_MGMT_PIN = 8'h23;
    localparam logic [7:0] ADDR_SCAN_CODE = 8'h5F;
    localparam logic [7:0] ADDR_BASE_HIGH = 8'h60;
    localparam logic [7:0] ADDR_BASE_LOW = 8'h61;
    localparam logic [7:0] ADDR_SLOW_CFG = 8'hF0;

    // ************************************************
    // field positions
    // ************************************************
    localparam int CTRL_GLOBAL_EN = 0;
    localparam int CTRL_GLOBAL_ST = 1;
    localparam int WK1_RING_A = 0;
    localparam int WK1_RING_B = 1;
    localparam int WK1_IR_FRAME = 2;
    localparam int WK1_KBD_DATA = 3;
    localparam int WK1_MOUSE_DATA = 4;
    localparam int WK1_KEY_MATCH = 5;
    localparam int WK1_FAN0 = 6;
    localparam int WK3_GROUP_IRQ = 3;
    localparam int EN2_TO_PIN = 7;
    localparam int EN2_TO_SLOT2 = 6;
    localparam int EN2_TO_WAKE = 5;
    localparam int PIN_POLARITY = 1;
    localparam int PIN_OPEN_DRAIN = 7;
    localparam int CFG_CLK_PRESENT = 0;
    localparam int CFG_KEY_OFF = 1;

    // synchronised pin vector layout
    localparam int NUM_GPIO = 6;
    localparam int PIN_RING_A = 6;
    localparam int PIN_RING_B = 7;
    localparam int PIN_KDAT = 8;
    localparam int PIN_MDAT = 9;
    localparam int PIN_KCLK = 10;
    localparam int PIN_SCLK = 11;
    localparam int NUM_PINS = 12;

    // ************************************************
    // reset values and timing
    // ************************************************
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] PIN_CTRL_RST = 8'h80;
    localparam logic [7:0] SCAN_CODE_RST = 8'h00;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLOW_PERIOD_NS = 30518;
    localparam logic [11:0] SLOW_DIV_CYCLES =
        12'(SLOW_PERIOD_NS / CLK_PERIOD_NS);
    localparam logic [3:0] KEY_FRAME_BITS = 4'hB;

    // ************************************************
    // types
    // ************************************************
    typedef struct packed {
        logic out;
        logic oe;
    } wesa_pin_t;

    localparam wesa_pin_t PIN_IDLE = '{out: 1'b0, oe: 1'b0};

    typedef enum logic [0:0] {
        KEY_IDLE = 1'b0,
        KEY_SHIFT = 1'b1
    } wesa_key_state_t;

endpackage

// File: rtl/wesa_aggregator.sv
// wake and management interrupt event aggregator
`timescale 1ns/1ns
`default_nettype none

module wesa_aggregator (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic nrst_trickle,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output var logic [7:0] reg_rdata,
    input wire logic [5:0] gpio_in,
    input wire logic [1:0] fan_event,
    input wire logic [7:0] mgmt_src_one,
    input wire logic [4:1] mgmt_src_two,
    input wire logic ir_irq,
    input wire logic ir_frame_ok,
    input wire logic ring_indicate_a_n,
    input wire logic ring_indicate_b_n,
    input wire logic kbd_data,
    input wire logic kbd_clk,
    input wire logic mouse_data,
    input wire logic slow_clk_ext,
    output var wesa_pkg::wesa_pin_t wake_out_n,
    output var wesa_pkg::wesa_pin_t mgmt_irq_out_n,
    output var logic irq_slot2_req,
    output var logic group_mgmt_irq
);
    import wesa_pkg::*;

    // ************************************************
    // pin synchronisers and edge detection
    // ************************************************
    logic [NUM_PINS-1:0] pins;
    logic [NUM_PINS-1:0] sync1_q;
    logic [NUM_PINS-1:0] sync2_q;
    logic [NUM_PINS-1:0] prev_q;
    logic [NUM_PINS-1:0] rise;
    logic [NUM_PINS-1:0] fall;
    logic [1:0] fan_prev_q;
    logic [1:0] fan_rise;
    logic ir_frame_q;
    logic [1:0] warm_q;

    assign pins = {slow_clk_ext, kbd_clk, mouse_data, kbd_data,
                   ring_indicate_b_n, ring_indicate_a_n, gpio_in};

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
            fan_prev_q <= 2'h0;
            ir_frame_q <= 1'b0;
            warm_q <= 2'h0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            fan_prev_q <= fan_event;
            ir_frame_q <= ir_frame_ok;
            warm_q <= warm_q + {1'b0, ~&warm_q};
        end
    end

    // no rise or fall edges until the chain holds real pin samples
    assign rise = sync2_q & ~prev_q & {NUM_PINS{&warm_q}};
    assign fall = ~sync2_q & prev_q & {NUM_PINS{&warm_q}};
    assign fan_rise = fan_event & ~fan_prev_q;

    // ************************************************
    // registers
    // ************************************************
    logic [7:0] we1_q, we1_d, we2_q, we2_d, we3_q, we3_d;
    logic [7:0] ws1_q, ws1_d, ws2_q, ws2_d;
    logic ws3_q, ws3_d;
    logic [7:0] me1_q, me1_d, me2_q, me2_d, me3_q, me3_d;
    logic [7:0] ms3_q, ms3_d;
    logic [5:0] pol_q, pol_d, dual_q, dual_d;
    logic [7:0] wpin_q, wpin_d, mpin_q, mpin_d;
    logic [7:0] base_hi_q, base_hi_d, base_lo_q, base_lo_d;
    logic [7:0] slow_cfg_q, slow_cfg_d;
    logic [7:0] scan_q, scan_d;
    logic gen_q, gen_d, gst_q, gst_d;
    logic ir_flag_q, ir_flag_d;
    logic [7:0] rdata_d;

    // gpio edge selection per pin
    logic [5:0] gpio_evt;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_GPIO; gi++) begin : g_gpio_edge
            assign gpio_evt[gi] = dual_q[gi] ? (rise[gi] | fall[gi])
                                : pol_q[gi] ? fall[gi] : rise[gi];
        end
    endgenerate

    // ************************************************
    // specific key matcher on the slow clock
    // ************************************************
    wesa_key_state_t key_state_q, key_state_d;
    logic [11:0] div_q, div_d;
    logic int_tick;
    logic ext_tick;
    logic slow_tick;
    logic key_on;
    logic kclk_q, kclk_d;
    logic [10:0] key_sh_q, key_sh_d;
    logic [3:0] key_cnt_q, key_cnt_d;
    logic key_match_q, key_match_d;
    logic [10:0] frame;

    assign int_tick = (div_q == SLOW_DIV_CYCLES - 12'h001);
    assign ext_tick = rise[PIN_SCLK];
    assign slow_tick = slow_cfg_q[CFG_CLK_PRESENT] ? ext_tick
                                                   : int_tick;
    assign key_on = ~slow_cfg_q[CFG_KEY_OFF];
    assign frame = {sync2_q[PIN_KDAT], key_sh_q[10:1]};

    always_comb begin
        div_d = int_tick ? 12'h000 : div_q + 12'h001;
        key_state_d = key_state_q;
        kclk_d = kclk_q;
        key_sh_d = key_sh_q;
        key_cnt_d = key_cnt_q;
        key_match_d = 1'b0;
        if (!key_on) begin
            div_d = 12'h000;
            key_state_d = KEY_IDLE;
            key_cnt_d = 4'h0;
            kclk_d = 1'b1;
        end else if (slow_tick) begin
            kclk_d = sync2_q[PIN_KCLK];
            if (kclk_q && !sync2_q[PIN_KCLK]) begin
                key_sh_d = frame;
                case (key_state_q)
                    KEY_IDLE: begin
                        key_state_d = KEY_SHIFT;
                        key_cnt_d = 4'h1;
                    end
                    KEY_SHIFT: begin
                        key_cnt_d = key_cnt_q + 4'h1;
                        if (key_cnt_q == KEY_FRAME_BITS - 4'h1) begin
                            // frame complete: start, data lsb first,
                            // odd parity, stop
                            key_state_d = KEY_IDLE;
                            key_cnt_d = 4'h0;
                            key_match_d = !frame[0] && frame[10]
                                && (^frame[9:1])
                                && (frame[8:1] == scan_q);
                        end
                    end
                    default: begin
                        key_state_d = KEY_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            div_q <= 12'h000;
            key_state_q <= KEY_IDLE;
            kclk_q <= 1'b1;
            key_sh_q <= '0;
            key_cnt_q <= 4'h0;
            key_match_q <= 1'b0;
        end else begin
            div_q <= div_d;
            key_state_q <= key_state_d;
            kclk_q <= kclk_d;
            key_sh_q <= key_sh_d;
            key_cnt_q <= key_cnt_d;
            key_match_q <= key_match_d;
        end
    end

    // ************************************************
    // event collection and group logic
    // ************************************************
    logic [7:0] wake_evt1;
    logic [7:0] wake_evt2;
    logic [7:0] mgmt_evt3;
    logic [7:0] mst2_view;
    logic grp;
    logic wake_pending;
    logic wake_new;
    logic wr_hit;

    assign wake_evt1 = {fan_rise, key_match_q,
                        fall[PIN_MDAT], fall[PIN_KDAT], ir_frame_q,
                        fall[PIN_RING_B], fall[PIN_RING_A]};
    assign wake_evt2 = {2'b00, gpio_evt};
    assign mgmt_evt3 = {fan_rise, gpio_evt};
    assign mst2_view = {3'b000, mgmt_src_two, ir_flag_q};

    assign grp = (|(mgmt_src_one & me1_q))
               | (|(mst2_view[4:0] & me2_q[4:0]))
               | (|(ms3_q & me3_q));

    assign wake_pending = (|(ws1_q & we1_q)) | (|(ws2_q & we2_q))
                        | (ws3_q & we3_q[WK3_GROUP_IRQ]);
    assign wake_new = (|(wake_evt1 & we1_q)) | (|(wake_evt2 & we2_q))
                    | (grp & me2_q[EN2_TO_WAKE] & we3_q[WK3_GROUP_IRQ]);

    assign wr_hit = reg_wr;

    // ************************************************
    // register file next state
    // ************************************************
    always_comb begin
        we1_d = we1_q;
        we2_d = we2_q;
        we3_d = we3_q;
        me1_d = me1_q;
        me2_d = me2_q;
        me3_d = me3_q;
        pol_d = pol_q;
        dual_d = dual_q;
        wpin_d = wpin_q;
        mpin_d = mpin_q;
        base_hi_d = base_hi_q;
        base_lo_d = base_lo_q;
        slow_cfg_d = slow_cfg_q;
        scan_d = scan_q;
        gen_d = gen_q;
        ws1_d = ws1_q;
        ws2_d = ws2_q;
        ws3_d = ws3_q;
        ms3_d = ms3_q;
        gst_d = gst_q;
        ir_flag_d = ir_flag_q;
        if (wr_hit) begin
            case (reg_addr)
                ADDR_WAKE_CTRL: begin
                    gen_d = reg_wdata[CTRL_GLOBAL_EN];
                    if (reg_wdata[CTRL_GLOBAL_ST] && !wake_pending) begin
                        gst_d = 1'b0;
                    end
                end
                ADDR_WAKE_ST1: ws1_d = ws1_q & ~reg_wdata;
                ADDR_WAKE_EN1: we1_d = reg_wdata;
                ADDR_WAKE_ST2: ws2_d = ws2_q & ~reg_wdata;
                ADDR_WAKE_EN2: we2_d = reg_wdata;
                ADDR_WAKE_ST3: begin
                    ws3_d = ws3_q & ~reg_wdata[WK3_GROUP_IRQ];
                end
                ADDR_WAKE_EN3: we3_d = reg_wdata;
                ADDR_MGMT_EN1: me1_d = reg_wdata;
                ADDR_MGMT_EN2: me2_d = reg_wdata;
                ADDR_MGMT_ST3: ms3_d = ms3_q & ~reg_wdata;
                ADDR_MGMT_EN3: me3_d = reg_wdata;
                ADDR_GPIO_POL: pol_d = reg_wdata[5:0];
                ADDR_GPIO_DUAL: dual_d = reg_wdata[5:0];
                ADDR_WAKE_PIN: wpin_d = reg_wdata;
                ADDR_MGMT_PIN: mpin_d = reg_wdata;
                ADDR_SCAN_CODE: scan_d = reg_wdata;
                ADDR_BASE_HIGH: base_hi_d = reg_wdata;
                ADDR_BASE_LOW: base_lo_d = reg_wdata;
                ADDR_SLOW_CFG: slow_cfg_d = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd && reg_addr == ADDR_MGMT_ST2) begin
            ir_flag_d = 1'b0;
        end
        // events win over a clear in the same cycle
        ws1_d = ws1_d | wake_evt1;
        ws2_d = ws2_d | wake_evt2;
        ws3_d = ws3_d | (grp & me2_q[EN2_TO_WAKE]);
        ms3_d = ms3_d | mgmt_evt3;
        ir_flag_d = ir_flag_d | ir_irq;
        gst_d = gst_d | wake_new;
    end

    // ************************************************
    // read data
    // ************************************************
    always_comb begin
        case (reg_addr)
            ADDR_WAKE_CTRL: rdata_d = {6'h00, gst_q, gen_q};
            ADDR_WAKE_ST1: rdata_d = ws1_q;
            ADDR_WAKE_EN1: rdata_d = we1_q;
            ADDR_WAKE_ST2: rdata_d = ws2_q;
            ADDR_WAKE_EN2: rdata_d = we2_q;
            ADDR_WAKE_ST3: rdata_d = {4'h0, ws3_q, 3'h0};
            ADDR_WAKE_EN3: rdata_d = we3_q;
            ADDR_MGMT_ST1: rdata_d = mgmt_src_one;
            ADDR_MGMT_EN1: rdata_d = me1_q;
            ADDR_MGMT_ST2: rdata_d = mst2_view;
            ADDR_MGMT_EN2: rdata_d = me2_q;
            ADDR_MGMT_ST3: rdata_d = ms3_q;
            ADDR_MGMT_EN3: rdata_d = me3_q;
            ADDR_GPIO_POL: rdata_d = {2'b00, pol_q};
            ADDR_GPIO_DUAL: rdata_d = {2'b00, dual_q};
            ADDR_WAKE_PIN: rdata_d = wpin_q;
            ADDR_MGMT_PIN: rdata_d = mpin_q;
            ADDR_SCAN_CODE: rdata_d = scan_q;
            ADDR_BASE_HIGH: rdata_d = base_hi_q;
            ADDR_BASE_LOW: rdata_d = base_lo_q;
            ADDR_SLOW_CFG: rdata_d = slow_cfg_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // ************************************************
    // output pins
    // ************************************************
    function automatic wesa_pin_t pin_drive(input logic active,
                                            input logic [7:0] ctl);
        logic level;
        wesa_pin_t p;
        level = ctl[PIN_POLARITY] ? active : ~active;
        if (ctl[PIN_OPEN_DRAIN]) begin
            p.out = 1'b0;
            p.oe = ~level;
        end else begin
            p.out = level;
            p.oe = 1'b1;
        end
        return p;
    endfunction

    wesa_pin_t wake_pin_d, mgmt_pin_d;
    logic wake_active;

    assign wake_active = gen_q & wake_pending;
    assign wake_pin_d = pin_drive(wake_active, wpin_q);
    assign mgmt_pin_d = pin_drive(grp & me2_q[EN2_TO_PIN], mpin_q);

    // ************************************************
    // state registers
    // ************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            we1_q <= REG_RST;
            we2_q <= REG_RST;
            we3_q <= REG_RST;
            me1_q <= REG_RST;
            me2_q <= REG_RST;
            me3_q <= REG_RST;
            pol_q <= 6'h00;
            dual_q <= 6'h00;
            wpin_q <= PIN_CTRL_RST;
            mpin_q <= PIN_CTRL_RST;
            base_hi_q <= REG_RST;
            base_lo_q <= REG_RST;
            slow_cfg_q <= REG_RST;
            gen_q <= 1'b0;
            gst_q <= 1'b0;
            ws1_q <= REG_RST;
            ws2_q <= REG_RST;
            ws3_q <= 1'b0;
            ms3_q <= REG_RST;
            ir_flag_q <= 1'b0;
            reg_rdata <= 8'h00;
            wake_out_n <= PIN_IDLE;
            mgmt_irq_out_n <= PIN_IDLE;
            irq_slot2_req <= 1'b0;
            group_mgmt_irq <= 1'b0;
        end else begin
            we1_q <= we1_d;
            we2_q <= we2_d;
            we3_q <= we3_d;
            me1_q <= me1_d;
            me2_q <= me2_d;
            me3_q <= me3_d;
            pol_q <= pol_d;
            dual_q <= dual_d;
            wpin_q <= wpin_d;
            mpin_q <= mpin_d;
            base_hi_q <= base_hi_d;
            base_lo_q <= base_lo_d;
            slow_cfg_q <= slow_cfg_d;
            gen_q <= gen_d;
            gst_q <= gst_d;
            ws1_q <= ws1_d;
            ws2_q <= ws2_d;
            ws3_q <= ws3_d;
            ms3_q <= ms3_d;
            ir_flag_q <= ir_flag_d;
            reg_rdata <= rdata_d;
            wake_out_n <= wake_pin_d;
            mgmt_irq_out_n <= mgmt_pin_d;
            irq_slot2_req <= grp & me2_q[EN2_TO_SLOT2];
            group_mgmt_irq <= grp;
        end
    end

    // scan code survives main reset
    always_ff @(posedge mclk or negedge nrst_trickle) begin
        if (!nrst_trickle) begin
            scan_q <= SCAN_CODE_RST;
        end else begin
            scan_q <= scan_d;
        end
    end

endmodule

`default_nettype wire

// File: verif/wesa_host_model.sv
// chipset-side model of the two open-drain event lines
`timescale 1ns/1ns
`default_nettype none
module wesa_host_model (
    input wire wesa_pkg::wesa_pin_t wake_out_n,
    input wire wesa_pkg::wesa_pin_t mgmt_irq_out_n,
    output wire logic wake_wire,
    output wire logic mgmt_wire
);
    import wesa_pkg::*;
    // board pull-ups hold a released line high
    assign wake_wire = wake_out_n.oe ? wake_out_n.out : 1'b1;
    assign mgmt_wire = mgmt_irq_out_n.oe ? mgmt_irq_out_n.out : 1'b1;
endmodule
`default_nettype wire

// File: verif/wesa_chk.sv
// port checker of the wake and management event aggregator
`timescale 1ns/1ns
`default_nettype none
module wesa_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] mgmt_src_one,
    input wire wesa_pkg::wesa_pin_t wake_out_n,
    input wire wesa_pkg::wesa_pin_t mgmt_irq_out_n,
    input wire logic irq_slot2_req,
    input wire logic group_mgmt_irq
);
    import wesa_pkg::*;
    // shadow: en1 32:25, en2 24:17, wake pin 16:9, mgmt pin 8:1, enable 0
    logic [32:0] sh_q, sh_d;
    always_comb begin
        sh_d = sh_q;
        if (reg_wr) begin
            case (reg_addr)
                ADDR_MGMT_EN1: sh_d[32:25] = reg_wdata;
                ADDR_MGMT_EN2: sh_d[24:17] = reg_wdata;
                ADDR_WAKE_PIN: sh_d[16:9] = reg_wdata;
                ADDR_MGMT_PIN: sh_d[8:1] = reg_wdata;
                ADDR_WAKE_CTRL: sh_d[0] = reg_wdata[CTRL_GLOBAL_EN];
                default: ;
            endcase
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sh_q <= {REG_RST, REG_RST, PIN_CTRL_RST, PIN_CTRL_RST, 1'h0};
        end else begin
            sh_q <= sh_d;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence live_on;
        (|(mgmt_src_one & sh_q[32:25])) [*5];
    endsequence
    chk_live_gate: assert property (live_on |-> group_mgmt_irq)
        else $error("enabled live source without group irq");
    chk_wake_gated: assert property (
        wake_out_n.oe && wake_out_n.out == $past(sh_q[10])
        |-> $past(sh_q[0])) else $error("wake driven while disabled");
    chk_open_drain: assert property (
        $past(sh_q[16]) |-> !(wake_out_n.oe && wake_out_n.out))
        else $error("open-drain wake pin driven high");
    chk_push_pull: assert property (
        !$past(sh_q[16]) |-> wake_out_n.oe)
        else $error("push-pull wake pin not driven");
    chk_mgmt_route: assert property (
        group_mgmt_irq && $past(sh_q[24]) |-> mgmt_irq_out_n.oe
        && mgmt_irq_out_n.out == $past(sh_q[2]))
        else $error("group irq not on its pin");
    chk_mgmt_off: assert property (
        !$past(sh_q[24]) |-> !(mgmt_irq_out_n.oe
        && mgmt_irq_out_n.out == $past(sh_q[2])))
        else $error("irq pin active while not routed");
    chk_slot_route: assert property (
        irq_slot2_req == (group_mgmt_irq && $past(sh_q[23])))
        else $error("slot request differs from routed group");
    chk_en_readback: assert property (reg_addr == ADDR_MGMT_EN1
        |=> reg_rdata == $past(sh_q[32:25]))
        else $error("enable one readback wrong");
    chk_pin_readback: assert property (
        reg_addr == ADDR_WAKE_PIN |=> reg_rdata == $past(sh_q[16:9]))
        else $error("wake pin control readback wrong");
    chk_unmapped_zero: assert property (reg_addr == 8'h40
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule
bind wesa_aggregator wesa_chk wesa_chk_inst (.*);
`default_nettype wire

// File: verif/wesa_aggregator_tb.sv
// self-checking bench of the wake and management event aggregator
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR %0t got %h exp %h", $time, a, e); end end
module wesa_aggregator_tb;
    import wesa_pkg::*;
    logic mclk = 0, nrst = 0, nrst_trickle = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, mgmt_src_one = 0;
    logic [5:0] gpio_in = 0;
    logic [1:0] fan_event = 0;
    logic [4:1] mgmt_src_two = 0;
    logic ir_irq = 0, ir_frame_ok = 0, ring_indicate_a_n = 1;
    logic ring_indicate_b_n = 1, kbd_data = 1, kbd_clk = 1, mouse_data = 1;
    logic slow_clk_ext = 0, irq_slot2_req, group_mgmt_irq, g;
    logic wake_wire, mgmt_wire, rd_d1 = 0, pr = 0, pr_d1 = 0;
    wesa_pin_t wake_out_n, mgmt_irq_out_n;
    logic [7:0] expq[$];
    logic [7:0] ev, got;
    logic [15:0] lf = 16'hd588;
    logic [3:0] gt [5] = '{4'h3, 4'h9, 4'ha, 4'hd, 4'hf};
    int srcs [5] = '{1, 2, 3, 4, 6};
    int err_total = 0, n_checks = 0, sdiv = 0;
    wesa_aggregator wesa_aggregator_inst (.*);
    wesa_host_model wesa_host_model_inst (.*);
    always #5 mclk = ~mclk;
    always @(negedge mclk) begin
        sdiv <= (sdiv == 4) ? 0 : sdiv + 1;
        if (sdiv == 4) slow_clk_ext <= ~slow_clk_ext;
    end
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // ************************************************
    // drivers and result watcher
    // ************************************************
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, d);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 0;
        @(negedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, e);
        reg_rd = 1;
        reg_addr = a;
        expq.push_back(e);
        @(negedge mclk);
        reg_rd = 0;
        @(negedge mclk);
    endtask
    // expected {wake line, irq line, group, slot}
    task automatic pins(input logic [3:0] e);
        pr = 1;
        expq.push_back({4'h0, e});
        @(negedge mclk);
        pr = 0;
        @(negedge mclk);
    endtask
    task automatic tog(input int b);
        case (b)
            1: ring_indicate_b_n = !ring_indicate_b_n;
            2: ir_frame_ok = !ir_frame_ok;
            3: kbd_data = !kbd_data;
            4: mouse_data = !mouse_data;
            default: fan_event[0] = !fan_event[0];
        endcase
    endtask
    task automatic kbd(input logic [7:0] b, input logic bad);
        logic [10:0] f;
        f = {1'b1, ~^b ^ bad, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            kbd_data = f[i];
            cyc(20);
            kbd_clk = 0;
            cyc(40);
            kbd_clk = 1;
            cyc(20);
        end
        cyc(40);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        rd_d1 <= reg_rd;
        pr_d1 <= pr;
    end
    always @(negedge mclk) begin
        if (rd_d1 || pr_d1) begin
            got = rd_d1 ? reg_rdata
                : {4'h0, wake_wire, mgmt_wire, group_mgmt_irq, irq_slot2_req};
            ev = expq.size() > 0 ? expq.pop_front() : 8'hxx;
            `CHK(got, ev)
        end
    end
    initial begin
        repeat (100000) @(posedge mclk);
        err_total++;
        close_out;
    end
    // ************************************************
    // scenarios
    // ************************************************
    initial begin
        cyc(12);
        nrst = 1;
        nrst_trickle = 1;
        cyc(2);
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h00);
        rd(ADDR_WAKE_CTRL, 8'h00);
        rd(ADDR_WAKE_PIN, 8'h80);
        rd(ADDR_MGMT_PIN, 8'h80);
        wr(ADDR_BASE_HIGH, lf[15:8]);
        rd(ADDR_BASE_HIGH, lf[15:8]);
        pins(4'b1100);
        $display("reset test done");
        wr(ADDR_MGMT_EN2, 8'he0);
        wr(ADDR_WAKE_EN3, 8'h08);
        for (int i = 0; i < 4; i++) begin
            lf = nx(lf);
            wr(ADDR_MGMT_EN1, lf[7:0]);
            mgmt_src_one = lf[15:8];
            mgmt_src_two = lf[3:0];
            g = |(lf[7:0] & lf[15:8]);
            cyc(4);
            wr(ADDR_WAKE_ST3, 8'h08);
            rd(ADDR_MGMT_ST1, lf[15:8]);
            wr(ADDR_MGMT_ST1, 8'hff);
            rd(ADDR_MGMT_ST1, lf[15:8]);
            rd(ADDR_MGMT_ST2, {3'b0, lf[3:0], 1'b0});
            rd(ADDR_WAKE_ST3, {4'h0, g, 3'b0});
            pins({1'b1, !g, g, g});
        end
        mgmt_src_two = 0;
        ir_irq = 1;
        cyc(2);
        ir_irq = 0;
        cyc(4);
        rd(ADDR_MGMT_ST2, 8'h01);
        rd(ADDR_MGMT_ST2, 8'h00);
        mgmt_src_one = 8'h01;
        wr(ADDR_MGMT_EN1, 8'h01);
        wr(ADDR_WAKE_CTRL, 8'h01);
        pins(4'b0011);
        wr(ADDR_MGMT_EN2, 8'hc0);
        wr(ADDR_WAKE_ST3, 8'h08);
        rd(ADDR_WAKE_ST3, 8'h00);
        pins(4'b1011);
        mgmt_src_one = 0;
        wr(ADDR_MGMT_EN2, 8'h00);
        wr(ADDR_WAKE_EN3, 8'h00);
        wr(ADDR_WAKE_CTRL, 8'h02);
        rd(ADDR_WAKE_CTRL, 8'h00);
        $display("routing test done");
        wr(ADDR_MGMT_EN3, 8'h01);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_GPIO_POL, {7'h0, gt[i][3]});
            wr(ADDR_GPIO_DUAL, {7'h0, gt[i][2]});
            gpio_in[0] = gt[i][1];
            cyc(4);
            rd(ADDR_MGMT_ST3, {7'h0, gt[i][0]});
            rd(ADDR_WAKE_ST2, {7'h0, gt[i][0]});
            wr(ADDR_MGMT_ST3, 8'h00);
            rd(ADDR_MGMT_ST3, {7'h0, gt[i][0]});
            wr(ADDR_MGMT_ST3, 8'h01);
            wr(ADDR_WAKE_ST2, 8'h01);
            rd(ADDR_MGMT_ST3, 8'h00);
        end
        wr(ADDR_MGMT_EN3, 8'h00);
        $display("gpio test done");
        wr(ADDR_WAKE_EN1, 8'h01);
        ring_indicate_a_n = 0;
        cyc(4);
        rd(ADDR_WAKE_ST1, 8'h01);
        rd(ADDR_WAKE_CTRL, 8'h02);
        pins(4'b1100);
        wr(ADDR_WAKE_CTRL, 8'h03);
        rd(ADDR_WAKE_CTRL, 8'h03);
        pins(4'b0100);
        wr(ADDR_WAKE_PIN, 8'h02);
        pins(4'b1100);
        wr(ADDR_WAKE_ST1, 8'h01);
        wr(ADDR_WAKE_CTRL, 8'h03);
        rd(ADDR_WAKE_CTRL, 8'h01);
        pins(4'b0100);
        wr(ADDR_WAKE_PIN, 8'h80);
        pins(4'b1100);
        ring_indicate_a_n = 1;
        for (int i = 0; i < 5; i++) begin
            tog(srcs[i]);
            cyc(4);
            tog(srcs[i]);
            cyc(4);
            rd(ADDR_WAKE_ST1, 8'h01 << srcs[i]);
            wr(ADDR_WAKE_ST1, 8'h01 << srcs[i]);
        end
        $display("wake source test done");
        wr(ADDR_WAKE_EN1, 8'h20);
        wr(ADDR_SCAN_CODE, 8'h5a);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_SLOW_CFG, i == 3 ? 8'h03 : 8'h01);
            kbd(i == 1 ? 8'h33 : 8'h5a, i == 0);
            rd(ADDR_WAKE_ST1, i == 2 ? 8'h28 : 8'h08);
            pins({i != 2, 3'b100});
            wr(ADDR_WAKE_ST1, 8'h28);
        end
        nrst = 0;
        cyc(3);
        nrst = 1;
        cyc(2);
        rd(ADDR_SCAN_CODE, 8'h5a);
        rd(ADDR_WAKE_EN1, 8'h00);
        rd(ADDR_MGMT_ST3, 8'h00);
        $display("key test done");
        close_out;
    end
endmodule
`default_nettype wire
